/* design/channel_stage.sv */
// Staged and applied ramp and peak settings of the pump channels.
module channel_stage #(
  parameter int CHANNELS = 4
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Staging write port.
  input wire logic wr_en_in,
  input wire logic [$clog2(CHANNELS)-1:0] wr_sel_in,
  input wire logic [7:0] wr_data_in,
  // Copy all staged settings into effect.
  input wire logic update_in,
  // Settings, eight bits per channel, channel 0 lowest.
  output logic [CHANNELS*8-1:0] staged_out,
  output logic [CHANNELS*8-1:0] applied_out
);

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      logic [7:0] staged_r;
      logic [7:0] staged_nxt;
      logic [7:0] applied_r;
      logic [7:0] applied_nxt;

      // A write only stages; the update copies every channel in the same cycle.
      always_comb begin
        staged_nxt = staged_r;
        applied_nxt = applied_r;
        if (wr_en_in && (wr_sel_in == ch)) begin
          staged_nxt = wr_data_in;
        end
        if (update_in) begin
          applied_nxt = staged_r;
        end
      end

      always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
          staged_r <= pump_regs_pkg::RESET_VALUE;
          applied_r <= pump_regs_pkg::RESET_VALUE;
        end else begin
          staged_r <= staged_nxt;
          applied_r <= applied_nxt;
        end
      end

      assign staged_out[ch*8 +: 8] = staged_r;
      assign applied_out[ch*8 +: 8] = applied_r;
    end
  endgenerate

endmodule

/* design/i2c_line_events.sv */
// Start, stop and clock edge detection on the sampled serial bus lines.
module i2c_line_events (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Bus lines, already synchronous to the clock.
  input wire logic scl_in,
  input wire logic sda_in,
  // One-cycle events.
  output logic start_out,
  output logic stop_out,
  output logic scl_rise_out,
  output logic scl_fall_out
);

  logic scl_r;
  logic sda_r;
  logic scl_nxt;
  logic sda_nxt;

  // Previous line levels; idle bus is high, so reset to high avoids a false edge.
  always_comb begin
    scl_nxt = scl_in;
    sda_nxt = sda_in;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
    end
  end

  // Data changing while the clock stays high marks a start or a stop.
  assign start_out = scl_r && scl_in && sda_r && !sda_in;
  assign stop_out = scl_r && scl_in && !sda_r && sda_in;
  assign scl_rise_out = !scl_r && scl_in;
  assign scl_fall_out = scl_r && !scl_in;

endmodule

/* design/piezo_pump_driver_regs.sv */
// Serial target and register bank of the four-channel piezo pump driver.
module piezo_pump_driver_regs #(
  parameter logic [3:0] PART_CODE = 4'h5, // Arbitrary value.
  parameter logic [3:0] SILICON_STEP = 4'h1, // Arbitrary value.
  parameter bit SINGLE_CHANNEL = 1'b0
) (
  // Clock and reset.
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Serial bus; data is open drain.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // Address select pins.
  input wire logic addr_pin_high_in,
  input wire logic addr_pin_low_in,
  // Thermal sensor level.
  input wire logic over_temp_in,
  // Settings towards the analog stages.
  output logic pump_enable_out,
  output logic [7:0] drive_tone_sel_out,
  output logic lx_ringing_suppress_out,
  output logic half_wave_out,
  output logic [1:0] edge_steepness_out,
  output logic [1:0] spread_sel_out,
  output logic [4:0] boost_switch_rate_out,
  output logic [pump_regs_pkg::NUM_CHANNELS*3-1:0] ramp_duration_out,
  output logic [pump_regs_pkg::NUM_CHANNELS*5-1:0] peak_level_out
);

  localparam int CH = pump_regs_pkg::NUM_CHANNELS;

  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;

  pump_regs_pkg::target_state_type state_r, state_nxt;
  pump_regs_pkg::byte_kind_type kind_r, kind_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic rw_r, rw_nxt;
  logic ack_r, ack_nxt;
  logic drive_r, drive_nxt;
  logic update_r, update_nxt;
  logic reg_wr;
  logic [7:0] rd_value;
  logic [6:0] own_addr;
  logic [1:0] chan_sel;

  logic trip_r, trip_nxt;
  logic en_r, en_nxt;
  logic pump_en_r, pump_en_nxt;
  logic [7:0] freq_r, freq_nxt;
  logic [7:0] wave_r, wave_nxt;
  logic [7:0] boost_r, boost_nxt;
  logic [7:0] sound_r, sound_nxt;
  logic chan_wr;
  logic [CH*8-1:0] staged;
  logic [CH*8-1:0] applied;

  i2c_line_events u_events (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .start_out(start_ev),
    .stop_out(stop_ev),
    .scl_rise_out(scl_rise),
    .scl_fall_out(scl_fall)
  );

  // Own address from fixed bits and the pins.
  assign own_addr = {pump_regs_pkg::TARGET_ADDR_FIXED, addr_pin_high_in, addr_pin_low_in};

  // Locations 0x06 to 0x09 map to channels 0 to 3; the two-bit sum wraps on purpose.
  assign chan_sel = ptr_r[1:0] + 2'h2;

  // Read data by location; unmapped and reserved locations read zero.
  always_comb begin
    rd_value = 8'h00;
    if (ptr_r == pump_regs_pkg::REG_PART_IDENTITY) begin
      rd_value = {PART_CODE, SILICON_STEP};
    end else if (ptr_r == pump_regs_pkg::REG_POWER_AND_THERMAL) begin
      rd_value = {trip_r, 6'h00, en_r};
    end else if (ptr_r == pump_regs_pkg::REG_DRIVE_FREQUENCY) begin
      rd_value = freq_r;
    end else if (ptr_r == pump_regs_pkg::REG_WAVEFORM_AND_SLOPE) begin
      rd_value = wave_r;
    end else if (ptr_r == pump_regs_pkg::REG_BOOST_SWITCHING) begin
      rd_value = boost_r;
    end else if (ptr_r == pump_regs_pkg::REG_SOUND_EFFECTS_UNUSED) begin
      rd_value = sound_r;
    end else if (ptr_r >= pump_regs_pkg::REG_CHANNEL1_RAMP_PEAK &&
                 ptr_r <= pump_regs_pkg::REG_CHANNEL4_RAMP_PEAK) begin
      rd_value = staged[chan_sel * 8 +: 8];
    end
  end

  // Serial target engine. A start restarts from any state, so a host that
  // breaks a byte off is always recovered at its next start.
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    ack_nxt = ack_r;
    drive_nxt = drive_r;
    update_nxt = 1'b0;
    reg_wr = 1'b0;
    if (start_ev) begin
      state_nxt = pump_regs_pkg::ST_RX_BYTE;
      kind_nxt = pump_regs_pkg::BYTE_ADDR;
      cnt_nxt = 4'h0;
      drive_nxt = 1'b0;
    end else if (stop_ev) begin
      state_nxt = pump_regs_pkg::ST_IDLE;
      drive_nxt = 1'b0;
    end else begin
      case (state_r)
        pump_regs_pkg::ST_RX_BYTE: begin
          if (scl_rise && cnt_r < pump_regs_pkg::BITS_PER_BYTE) begin
            shift_nxt = {shift_r[6:0], sda_in};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == pump_regs_pkg::BITS_PER_BYTE) begin
            cnt_nxt = 4'h0;
            state_nxt = pump_regs_pkg::ST_ACK;
            drive_nxt = 1'b1;
            case (kind_r)
              pump_regs_pkg::BYTE_ADDR: begin
                if (shift_r[7:1] == own_addr) begin
                  rw_nxt = shift_r[0];
                end else begin
                  state_nxt = pump_regs_pkg::ST_IDLE;
                  drive_nxt = 1'b0;
                end
              end
              pump_regs_pkg::BYTE_REG: begin
                ptr_nxt = shift_r;
                if (shift_r == pump_regs_pkg::REG_UPDATE_COMMAND) begin
                  update_nxt = 1'b1;
                end
              end
              default: begin
                reg_wr = 1'b1;
                ptr_nxt = ptr_r + 8'h01;
              end
            endcase
          end
        end
        pump_regs_pkg::ST_ACK: begin
          if (scl_fall) begin
            drive_nxt = 1'b0;
            if (kind_r == pump_regs_pkg::BYTE_ADDR && rw_r) begin
              state_nxt = pump_regs_pkg::ST_TX_BYTE;
              shift_nxt = rd_value;
              drive_nxt = !rd_value[7];
              cnt_nxt = 4'h1;
              ptr_nxt = ptr_r + 8'h01;
            end else begin
              state_nxt = pump_regs_pkg::ST_RX_BYTE;
              kind_nxt = (kind_r == pump_regs_pkg::BYTE_ADDR) ?
                         pump_regs_pkg::BYTE_REG : pump_regs_pkg::BYTE_DATA;
            end
          end
        end
        pump_regs_pkg::ST_TX_BYTE: begin
          if (scl_fall) begin
            if (cnt_r == pump_regs_pkg::BITS_PER_BYTE) begin
              state_nxt = pump_regs_pkg::ST_HOST_ACK;
              drive_nxt = 1'b0;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              drive_nxt = !shift_r[6];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        pump_regs_pkg::ST_HOST_ACK: begin
          // A host that answers not-acknowledge ends the read.
          if (scl_rise) begin
            ack_nxt = !sda_in;
          end else if (scl_fall) begin
            if (ack_r) begin
              state_nxt = pump_regs_pkg::ST_TX_BYTE;
              shift_nxt = rd_value;
              drive_nxt = !rd_value[7];
              cnt_nxt = 4'h1;
              ptr_nxt = ptr_r + 8'h01;
            end else begin
              state_nxt = pump_regs_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_nxt = pump_regs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_r <= pump_regs_pkg::ST_IDLE;
      kind_r <= pump_regs_pkg::BYTE_ADDR;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      ack_r <= 1'b0;
      drive_r <= 1'b0;
      update_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      ack_r <= ack_nxt;
      drive_r <= drive_nxt;
      update_r <= update_nxt;
    end
  end

  // Register bank. Identity is fixed; writes to it and to 0x0A/0x0B do nothing.
  always_comb begin
    trip_nxt = trip_r || over_temp_in;
    en_nxt = en_r;
    freq_nxt = freq_r;
    wave_nxt = wave_r;
    boost_nxt = boost_r;
    sound_nxt = sound_r;
    if (reg_wr) begin
      if (ptr_r == pump_regs_pkg::REG_POWER_AND_THERMAL) begin
        en_nxt = shift_r[pump_regs_pkg::ENABLE_BIT];
      end else if (ptr_r == pump_regs_pkg::REG_DRIVE_FREQUENCY) begin
        freq_nxt = shift_r;
      end else if (ptr_r == pump_regs_pkg::REG_WAVEFORM_AND_SLOPE) begin
        wave_nxt = shift_r & pump_regs_pkg::MASK_WAVEFORM;
      end else if (ptr_r == pump_regs_pkg::REG_BOOST_SWITCHING) begin
        boost_nxt = shift_r & pump_regs_pkg::MASK_BOOST;
      end else if (ptr_r == pump_regs_pkg::REG_SOUND_EFFECTS_UNUSED) begin
        sound_nxt = shift_r;
      end
    end
    // Trip and enable gate only pump_enable_out; the settings and their outputs are kept.
    pump_en_nxt = en_nxt && !trip_nxt;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      trip_r <= 1'b0;
      en_r <= 1'b0;
      pump_en_r <= 1'b0;
      freq_r <= pump_regs_pkg::RESET_VALUE;
      wave_r <= pump_regs_pkg::RESET_VALUE;
      boost_r <= pump_regs_pkg::RESET_VALUE;
      sound_r <= pump_regs_pkg::RESET_VALUE;
    end else begin
      trip_r <= trip_nxt;
      en_r <= en_nxt;
      pump_en_r <= pump_en_nxt;
      freq_r <= freq_nxt;
      wave_r <= wave_nxt;
      boost_r <= boost_nxt;
      sound_r <= sound_nxt;
    end
  end

  assign chan_wr = reg_wr && ptr_r >= pump_regs_pkg::REG_CHANNEL1_RAMP_PEAK &&
                   ptr_r <= pump_regs_pkg::REG_CHANNEL4_RAMP_PEAK;

  channel_stage #(.CHANNELS(CH)) u_stage (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .wr_en_in(chan_wr),
    .wr_sel_in(chan_sel),
    .wr_data_in(shift_r),
    .update_in(update_r),
    .staged_out(staged),
    .applied_out(applied)
  );

  // Open drain: only ever pull low.
  assign sda_out = 1'b0;
  assign sda_oe_n_out = !drive_r;

  assign pump_enable_out = pump_en_r;
  assign drive_tone_sel_out = freq_r;
  assign lx_ringing_suppress_out = wave_r[pump_regs_pkg::DAMP_BIT];
  assign half_wave_out = wave_r[pump_regs_pkg::HALF_WAVE_BIT];
  assign edge_steepness_out = wave_r[1:0];
  assign spread_sel_out = boost_r[7:6];
  assign boost_switch_rate_out = boost_r[4:0];

  // Per-channel field split; the single-channel variant drives only the last.
  genvar c;
  generate
    for (c = 0; c < CH; c++) begin : g_out
      logic live;
      assign live = !SINGLE_CHANNEL || (c == CH - 1);
      assign ramp_duration_out[c*3 +: 3] = live ?
        applied[c*8 + pump_regs_pkg::RAMP_LSB +: 3] : 3'h0;
      assign peak_level_out[c*5 +: 5] = live ? applied[c*8 +: 5] : 5'h00;
    end
  endgenerate

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  trip_latched_a: assert property (trip_r |=> trip_r)
    else $error("Thermal trip flag dropped without reset.");
  outputs_off_a: assert property (trip_r || !en_r |-> !pump_enable_out)
    else $error("Outputs on while tripped or disabled.");
  trip_set_a: assert property (over_temp_in |=> trip_r &&
      (ptr_r != pump_regs_pkg::REG_POWER_AND_THERMAL || rd_value[7]))
    else $error("Over temperature not reflected in status.");
  addr_reject_a: assert property (state_r == pump_regs_pkg::ST_RX_BYTE &&
      kind_r == pump_regs_pkg::BYTE_ADDR && cnt_r == 4'h8 && scl_fall && !start_ev &&
      !stop_ev && shift_r[7:1] != own_addr |=> state_r == pump_regs_pkg::ST_IDLE && !drive_r)
    else $error("Foreign address acknowledged.");
  rw_capture_a: assert property (state_r == pump_regs_pkg::ST_RX_BYTE &&
      kind_r == pump_regs_pkg::BYTE_ADDR && cnt_r == 4'h8 && scl_fall && !start_ev &&
      !stop_ev && shift_r[7:1] == own_addr |=> rw_r == $past(shift_r[0]) && drive_r)
    else $error("Direction bit not captured.");
  update_apply_a: assert property (update_r |=> applied == $past(staged))
    else $error("Update did not apply staged settings.");
  staged_hold_a: assert property (!update_r |=> $stable(applied))
    else $error("Applied settings changed without update.");
  dont_care_a: assert property ((wave_r & ~pump_regs_pkg::MASK_WAVEFORM) == 8'h00 &&
      (boost_r & ~pump_regs_pkg::MASK_BOOST) == 8'h00)
    else $error("Don't-care bits stored.");
  single_chan_a: assert property (SINGLE_CHANNEL |->
      ramp_duration_out[CH*3-4:0] == '0 && peak_level_out[CH*5-6:0] == '0)
    else $error("Inactive channel driven on single-channel variant.");
  id_read_a: assert property (ptr_r == pump_regs_pkg::REG_PART_IDENTITY |->
      rd_value == {PART_CODE, SILICON_STEP})
    else $error("Identity register read wrong.");

  write_cov_c: cover property (reg_wr ##[1:200] update_r);
  read_cov_c: cover property (state_r == pump_regs_pkg::ST_HOST_ACK && ack_r && scl_fall);
  trip_cov_c: cover property (en_r && $rose(trip_r));
  shutdown_cov_c: cover property ($fell(en_r));

endmodule

/* design/pump_regs_pkg.sv */
// Shared constants and types of the piezo pump driver register bank.
package pump_regs_pkg;

  // Upper five bits of the serial target address.
  localparam logic [4:0] TARGET_ADDR_FIXED = 5'h1e;

  // Register locations.
  localparam logic [7:0] REG_PART_IDENTITY = 8'h00;
  localparam logic [7:0] REG_POWER_AND_THERMAL = 8'h01;
  localparam logic [7:0] REG_DRIVE_FREQUENCY = 8'h02;
  localparam logic [7:0] REG_WAVEFORM_AND_SLOPE = 8'h03;
  localparam logic [7:0] REG_BOOST_SWITCHING = 8'h04;
  localparam logic [7:0] REG_SOUND_EFFECTS_UNUSED = 8'h05;
  localparam logic [7:0] REG_CHANNEL1_RAMP_PEAK = 8'h06;
  localparam logic [7:0] REG_CHANNEL4_RAMP_PEAK = 8'h09;
  localparam logic [7:0] REG_UPDATE_COMMAND = 8'h0a;
  localparam logic [7:0] REG_RESERVED = 8'h0b;

  // Value of every writable register after power-on.
  localparam logic [7:0] RESET_VALUE = 8'h00;

  // Writable bit masks; bits outside a mask are don't-care and read as zero.
  localparam logic [7:0] MASK_WAVEFORM = 8'h4f;
  localparam logic [7:0] MASK_BOOST = 8'hdf;

  // Field positions.
  localparam int THERMAL_BIT = 7;
  localparam int ENABLE_BIT = 0;
  localparam int DAMP_BIT = 6;
  localparam int HALF_WAVE_BIT = 3;
  localparam int RAMP_MSB = 7;
  localparam int RAMP_LSB = 5;
  localparam int PEAK_MSB = 4;
  localparam int RAMP_BITS = 3;
  localparam int PEAK_BITS = 5;

  // Channel count and bits per serial byte.
  localparam int NUM_CHANNELS = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Serial target engine states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX_BYTE,
    ST_ACK,
    ST_TX_BYTE,
    ST_HOST_ACK
  } target_state_type;

  // Meaning of the byte being received.
  typedef enum logic [1:0] {
    BYTE_ADDR,
    BYTE_REG,
    BYTE_DATA
  } byte_kind_type;

endpackage

/* sim/i2c_host_model.sv */
// Behavioural serial bus host that reaches the register bank.
module i2c_host_model (
  // Clock.
  input wire logic sys_clk_in,
  // Resolved data line.
  input wire logic sda_line_in,
  // Host line levels; a high level means released to the pull-up.
  output logic scl_out,
  output logic sda_out,
  // One pulse with the byte of each finished read.
  output logic rd_valid_out,
  output logic [7:0] rd_data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Clock cycles per bus phase; the bench raises it to act as a slow host.
  int phase = 4;

  // The bus idles high, so both lines start released.
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    rd_valid_out = 1'b0;
    rd_data_out = 8'h00;
  end

  task automatic tick();
    repeat (phase) @(posedge sys_clk_in);
  endtask

  // Data only moves while the clock is low, so no bit looks like a frame edge.
  task automatic put_bit(input logic b);
    sda_out <= b;
    tick();
    scl_out <= 1'b1;
    tick();
    scl_out <= 1'b0;
    tick();
  endtask

  task automatic get_bit(output logic b);
    sda_out <= 1'b1;
    tick();
    scl_out <= 1'b1;
    tick();
    b = sda_line_in;
    scl_out <= 1'b0;
    tick();
  endtask

  // Works as a repeated start as well, since data rises before the clock.
  task automatic start();
    sda_out <= 1'b1;
    tick();
    scl_out <= 1'b1;
    tick();
    sda_out <= 1'b0;
    tick();
    scl_out <= 1'b0;
    tick();
  endtask

  task automatic stop();
    sda_out <= 1'b0;
    tick();
    scl_out <= 1'b1;
    tick();
    sda_out <= 1'b1;
    tick();
  endtask

  task automatic send_byte(input logic [7:0] d, output bit acked);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    acked = (b === 1'b0);
  endtask

  // Sends the pointer and, when asked, one data byte.
  task automatic write_reg(input logic [6:0] addr, input logic [7:0] ptr,
      input logic [7:0] data, input bit with_data, output bit acked);
    bit a;
    start();
    send_byte({addr, 1'b0}, acked);
    if (acked) begin
      send_byte(ptr, a);
      if (with_data) begin
        send_byte(data, a);
      end
    end
    stop();
  endtask

  // Pointer write, repeated start, one byte in, then not-acknowledge and stop.
  task automatic read_reg(input logic [6:0] addr, input logic [7:0] ptr);
    logic [7:0] d;
    logic b;
    bit a;
    start();
    send_byte({addr, 1'b0}, a);
    send_byte(ptr, a);
    start();
    send_byte({addr, 1'b1}, a);
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(1'b1);
    stop();
    rd_data_out <= d;
    rd_valid_out <= 1'b1;
    @(posedge sys_clk_in);
    rd_valid_out <= 1'b0;
  endtask
endmodule

/* sim/test_piezo_pump_driver_regs.sv */
// Self-checking bench of the pump driver register bank.
module test_piezo_pump_driver_regs;
  timeunit 1ns;
  timeprecision 1ps;

  // Identity codes handed to the design; the values are arbitrary.
  localparam logic [3:0] ID_PART = 4'h6;
  localparam logic [3:0] ID_STEP = 4'h3;
  localparam int CYCLE_LIMIT = 90000;

  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic pin_hi = 1'b0;
  logic pin_lo = 1'b0;
  logic over_temp = 1'b0;
  logic scl;
  logic sda_h;
  logic sda_out;
  logic sda_oe_n_out;
  logic sda_line;
  logic rd_valid;
  logic [7:0] rd_data;
  logic pump_enable;
  logic [7:0] tone;
  logic lx_damp;
  logic half_wave;
  logic [1:0] steep;
  logic [1:0] spread;
  logic [4:0] boost_rate;
  logic [11:0] ramp;
  logic [19:0] peak;
  logic sda1_out;
  logic sda1_oe_n;
  logic [11:0] ramp1;
  logic [19:0] peak1;
  logic [7:0] tone_val;
  logic [7:0] exp_q[$];
  logic [7:0] ch[4];
  logic [31:0] seed = 32'd76194;
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  bit a;
  wire logic [6:0] dev_addr = {pump_regs_pkg::TARGET_ADDR_FIXED, pin_hi, pin_lo};

  // The data wire is pulled up, so it is low whenever any of the three parties pulls it.
  assign sda_line = sda_h & (sda_oe_n_out ? 1'b1 : sda_out) & (sda1_oe_n ? 1'b1 : sda1_out);

  always #2 sys_clk_in = ~sys_clk_in;

  piezo_pump_driver_regs #(.PART_CODE(ID_PART), .SILICON_STEP(ID_STEP),
      .SINGLE_CHANNEL(1'b0)) DUT (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .addr_pin_high_in(pin_hi),
    .addr_pin_low_in(pin_lo), .over_temp_in(over_temp), .pump_enable_out(pump_enable),
    .drive_tone_sel_out(tone), .lx_ringing_suppress_out(lx_damp),
    .half_wave_out(half_wave), .edge_steepness_out(steep), .spread_sel_out(spread),
    .boost_switch_rate_out(boost_rate), .ramp_duration_out(ramp), .peak_level_out(peak));

  // Single-channel variant on the same bus; it answers exactly alike, so the wired line agrees.
  piezo_pump_driver_regs #(.PART_CODE(ID_PART), .SILICON_STEP(ID_STEP),
      .SINGLE_CHANNEL(1'b1)) single_dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda1_out), .sda_oe_n_out(sda1_oe_n), .addr_pin_high_in(pin_hi),
    .addr_pin_low_in(pin_lo), .over_temp_in(over_temp), .pump_enable_out(),
    .drive_tone_sel_out(), .lx_ringing_suppress_out(), .half_wave_out(),
    .edge_steepness_out(), .spread_sel_out(), .boost_switch_rate_out(),
    .ramp_duration_out(ramp1), .peak_level_out(peak1));

  i2c_host_model host (
    .sys_clk_in(sys_clk_in), .sda_line_in(sda_line), .scl_out(scl), .sda_out(sda_h),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Only locations below the reserved one are used, and the sound register is never written.
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host.write_reg(dev_addr, p, d, 1'b1, a);
    check("write ack", 1, a);
  endtask

  // The expected byte is noted first; the watcher below compares it on arrival.
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    host.read_reg(dev_addr, p);
  endtask

  // Each finished read is matched against the oldest note.
  always @(posedge sys_clk_in) begin
    if (rd_valid === 1'b1) begin
      check("read data", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rd_data);
    end
  end

  // A hang is cut short after a fixed number of cycles.
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_LIMIT) begin
      err_total++;
      $display("Error timeout expected end of run seen hang");
      tally_and_finish();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    rd(8'h00, {ID_PART, ID_STEP});
    for (int r = 1; r < 10; r++) begin
      rd(r[7:0], 8'h00);
    end
    wr(8'h00, 8'hff);
    rd(8'h00, {ID_PART, ID_STEP});
    $display("test power-on values done");
    for (int k = 0; k < 4; k++) begin
      {pin_hi, pin_lo} <= k[1:0];
      seed = lfsr_next(seed);
      tone_val = seed[7:0];
      @(posedge sys_clk_in);
      wr(8'h02, seed[7:0]);
      check("tone", seed[7:0], tone);
      host.write_reg(dev_addr ^ 7'h01, 8'h02, 8'h00, 1'b1, a);
      check("foreign ack", 0, a);
      check("tone kept", seed[7:0], tone);
    end
    $display("test addressing done");
    for (int i = 0; i < 16; i++) begin
      seed = lfsr_next(seed);
      wr(8'h03, {seed[7:4], i[3:0]});
      check("damping", seed[6], lx_damp);
      check("half wave", i[3], half_wave);
      check("steepness", i[1:0], steep);
      rd(8'h03, {seed[7:4], i[3:0]} & pump_regs_pkg::MASK_WAVEFORM);
    end
    for (int i = 0; i < 4; i++) begin
      seed = lfsr_next(seed);
      wr(8'h04, {i[1:0], seed[5:0]});
      check("spread", i[1:0], spread);
      check("boost rate", seed[4:0], boost_rate);
      rd(8'h04, {i[1:0], seed[5:0]} & pump_regs_pkg::MASK_BOOST);
    end
    $display("test shape and boost done");
    host.phase = 7;
    for (int c = 0; c < 4; c++) begin
      seed = lfsr_next(seed);
      ch[c] = seed[7:0];
      wr(8'h06 + c[7:0], ch[c]);
    end
    check("ramp staged", 0, ramp);
    check("peak staged", 0, peak);
    for (int c = 0; c < 4; c++) begin
      rd(8'h06 + c[7:0], ch[c]);
    end
    host.write_reg(dev_addr, 8'h0a, 8'h00, 1'b0, a);
    check("single ramp", {ch[3][7:5], 9'h000}, ramp1);
    check("single peak", {ch[3][4:0], 15'h0000}, peak1);
    for (int c = 0; c < 4; c++) begin
      check("ramp applied", ch[c][7:5], ramp[c*3+:3]);
      check("peak applied", ch[c][4:0], peak[c*5+:5]);
    end
    host.phase = 4;
    $display("test channel update done");
    wr(8'h01, 8'hff);
    check("enable", 1, pump_enable);
    rd(8'h01, 8'h01);
    wr(8'h01, 8'h00);
    check("shutdown", 0, pump_enable);
    check("tone kept off", tone_val, tone);
    rd(8'h02, tone_val);
    wr(8'h01, 8'h01);
    over_temp <= 1'b1;
    @(posedge sys_clk_in);
    over_temp <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    check("trip off", 0, pump_enable);
    rd(8'h01, 8'h81);
    wr(8'h01, 8'h01);
    check("trip held", 0, pump_enable);
    rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    $display("test enable and thermal done");
    tally_and_finish();
  end
endmodule
